// ### logic/uer_pkg.sv
package uer_pkg;

	// Register byte addresses
	localparam logic [11:0] UER_FLAGS_OFS = 12'h104;
	localparam logic [11:0] UER_SUPP_OFS  = 12'h108;
	localparam logic [11:0] UER_CLS_OFS   = 12'h10C;

	// Bit positions of the implemented errors
	localparam int UER_B_TRAIN  = 0;
	localparam int UER_B_DLP    = 4;
	localparam int UER_B_POISON = 12;
	localparam int UER_B_FCP    = 13;
	localparam int UER_B_CTO    = 14;
	localparam int UER_B_CA     = 15;
	localparam int UER_B_UC     = 16;
	localparam int UER_B_ROF    = 17;
	localparam int UER_B_MAL    = 18;
	localparam int UER_B_ECRC   = 19;
	localparam int UER_B_UR     = 20;

	// Implemented bits; every other bit reads as zero
	localparam logic [31:0] UER_IMPL_MASK = 32'h001F_F011;

	// Reset values
	localparam logic [31:0] UER_FLAGS_RST = 32'h0000_0000;
	localparam logic [31:0] UER_SUPP_RST  = 32'h0000_0000;
	localparam logic [31:0] UER_CLS_RST   = 32'h0006_2011;
	localparam logic [31:0] UER_ZERO      = 32'h0000_0000;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} uer_bus_req_t;

	typedef struct packed {
		logic training;
		logic dlp;
		logic poison_rx;
		logic poison_tx;
		logic fc_proto;
		logic cpl_timeout;
		logic cpl_abort;
		logic unexp_cpl;
		logic rx_overflow;
		logic malformed;
		logic ecrc;
		logic unsup_req;
	} uer_evt_t;

	typedef struct packed {
		logic       valid;
		logic       fatal;
		logic [4:0] err_pos;
		logic       hdr_log;
	} uer_msg_t;

	typedef struct packed {
		logic [31:0] flags;
		logic [31:0] supp;
		logic [31:0] cls;
		logic [31:0] pend;
		logic [31:0] rdata;
		uer_msg_t    msg;
		logic        irq;
	} uer_state_t;

	// Places each event line on its status bit position
	function automatic logic [31:0] uer_evt_vec(input uer_evt_t e);
		logic [31:0] v;
		v = UER_ZERO;
		v[UER_B_TRAIN]  = e.training;
		v[UER_B_DLP]    = e.dlp;
		v[UER_B_POISON] = e.poison_rx | e.poison_tx;
		v[UER_B_FCP]    = e.fc_proto;
		v[UER_B_CTO]    = e.cpl_timeout;
		v[UER_B_CA]     = e.cpl_abort;
		v[UER_B_UC]     = e.unexp_cpl;
		v[UER_B_ROF]    = e.rx_overflow;
		v[UER_B_MAL]    = e.malformed;
		v[UER_B_ECRC]   = e.ecrc;
		v[UER_B_UR]     = e.unsup_req;
		return v;
	endfunction

endpackage

// ### logic/uer_regs.sv
`timescale 1ns/1ps

module uer_regs
	import uer_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         por,
	input  wire uer_bus_req_t bus,
	input  wire uer_evt_t     evt,
	output      logic [31:0]  rd_data,
	output      uer_msg_t     msg,
	output      logic         irq
);

	uer_state_t  q;
	uer_state_t  d;
	logic [31:0] evt_vec;

	assign evt_vec = uer_evt_vec(evt) & UER_IMPL_MASK;

	always_comb begin
		logic [31:0] clr;
		logic [31:0] sent;
		logic        found;
		clr   = UER_ZERO;
		sent  = UER_ZERO;
		found = 1'b0;
		d     = q;
		// Write one to clear status
		if (bus.wr && bus.addr == UER_FLAGS_OFS) begin
			clr = bus.wdata & UER_IMPL_MASK;
		end
		if (bus.wr && bus.addr == UER_SUPP_OFS) begin
			d.supp = bus.wdata & UER_IMPL_MASK;
		end
		if (bus.wr && bus.addr == UER_CLS_OFS) begin
			d.cls = bus.wdata & UER_IMPL_MASK;
		end
		// A new event wins over a clear in the same cycle
		d.flags = (q.flags & ~clr) | evt_vec;
		// Lowest pending error goes out first, one per cycle
		d.msg.valid   = 1'b0;
		d.msg.hdr_log = 1'b0;
		d.msg.fatal   = 1'b0;
		for (int i = 0; i < 32; i++) begin
			if (!found && q.pend[i]) begin
				found         = 1'b1;
				sent[i]       = 1'b1;
				d.msg.valid   = 1'b1;
				d.msg.hdr_log = 1'b1;
				d.msg.fatal   = q.cls[i];
				d.msg.err_pos = 5'(i);
			end
		end
		// Errors masked in q.supp never become pending; a mask written this cycle acts from the next
		d.pend = (q.pend & ~sent) | (evt_vec & ~q.supp);
		d.rdata = UER_ZERO;
		if (bus.rd) begin
			case (bus.addr)
				UER_FLAGS_OFS: d.rdata = q.flags;
				UER_SUPP_OFS:  d.rdata = q.supp;
				UER_CLS_OFS:   d.rdata = q.cls;
				default:       d.rdata = UER_ZERO;
			endcase
		end
		d.irq = |(d.flags & ~d.supp);
	end

	always_ff @(posedge clk) begin
		if (por) begin
			q.flags <= UER_FLAGS_RST;
			q.supp  <= UER_SUPP_RST;
			q.cls   <= UER_CLS_RST;
			q.pend  <= UER_ZERO;
			q.rdata <= UER_ZERO;
			q.msg   <= '0;
			q.irq   <= 1'b0;
		end else if (rst) begin
			// Sticky registers keep their contents
			q.flags <= q.flags;
			q.supp  <= q.supp;
			q.cls   <= q.cls;
			q.pend  <= UER_ZERO;
			q.rdata <= UER_ZERO;
			q.msg   <= '0;
			q.irq   <= |(q.flags & ~q.supp);
		end else begin
			q <= d;
		end
	end

	assign rd_data = q.rdata;
	assign msg     = q.msg;
	assign irq     = q.irq;

	property p_train_set;
		@(posedge clk) disable iff (rst || por)
		evt.training |=> q.flags[UER_B_TRAIN];
	endproperty
	a_train_set: assert property (p_train_set)
		else $error("training event not flagged");

	property p_dlp_set;
		@(posedge clk) disable iff (rst || por)
		evt.dlp |=> q.flags[UER_B_DLP];
	endproperty
	a_dlp_set: assert property (p_dlp_set)
		else $error("link protocol event not flagged");

	property p_poison_set;
		@(posedge clk) disable iff (rst || por)
		(evt.poison_rx || evt.poison_tx) |=> q.flags[UER_B_POISON];
	endproperty
	a_poison_set: assert property (p_poison_set)
		else $error("poisoned TLP not flagged");

	property p_fcp_set;
		@(posedge clk) disable iff (rst || por)
		evt.fc_proto |=> q.flags[UER_B_FCP];
	endproperty
	a_fcp_set: assert property (p_fcp_set)
		else $error("flow control error not flagged");

	property p_cto_set;
		@(posedge clk) disable iff (rst || por)
		evt.cpl_timeout |=> q.flags[UER_B_CTO];
	endproperty
	a_cto_set: assert property (p_cto_set)
		else $error("completion timeout not flagged");

	property p_ca_set;
		@(posedge clk) disable iff (rst || por)
		evt.cpl_abort |=> q.flags[UER_B_CA];
	endproperty
	a_ca_set: assert property (p_ca_set)
		else $error("completer abort not flagged");

	property p_uc_set;
		@(posedge clk) disable iff (rst || por)
		evt.unexp_cpl |=> q.flags[UER_B_UC];
	endproperty
	a_uc_set: assert property (p_uc_set)
		else $error("unexpected completion not flagged");

	property p_rof_set;
		@(posedge clk) disable iff (rst || por)
		evt.rx_overflow |=> q.flags[UER_B_ROF];
	endproperty
	a_rof_set: assert property (p_rof_set)
		else $error("receiver overflow not flagged");

	property p_mal_set;
		@(posedge clk) disable iff (rst || por)
		evt.malformed |=> q.flags[UER_B_MAL];
	endproperty
	a_mal_set: assert property (p_mal_set)
		else $error("malformed TLP not flagged");

	property p_ecrc_set;
		@(posedge clk) disable iff (rst || por)
		evt.ecrc |=> q.flags[UER_B_ECRC];
	endproperty
	a_ecrc_set: assert property (p_ecrc_set)
		else $error("ECRC error not flagged");

	property p_ur_set;
		@(posedge clk) disable iff (rst || por)
		evt.unsup_req |=> q.flags[UER_B_UR];
	endproperty
	a_ur_set: assert property (p_ur_set)
		else $error("unsupported request not flagged");

	property p_rsvd_zero;
		@(posedge clk) disable iff (rst || por)
		$past(bus.rd) |-> (q.rdata & ~UER_IMPL_MASK) == UER_ZERO;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved bits read nonzero");

	property p_train_masked;
		@(posedge clk) disable iff (rst || por)
		evt.training && q.supp[UER_B_TRAIN] && !q.pend[UER_B_TRAIN]
		|=> !q.pend[UER_B_TRAIN];
	endproperty
	a_train_masked: assert property (p_train_masked)
		else $error("masked training error queued");

	property p_masked_no_pend;
		@(posedge clk) disable iff (rst || por)
		(evt_vec & q.supp & ~q.pend) != UER_ZERO
		|=> ((q.pend & $past(evt_vec) & $past(q.supp)) == UER_ZERO);
	endproperty
	a_masked_no_pend: assert property (p_masked_no_pend)
		else $error("masked error queued for message");

	property p_poison_masked;
		@(posedge clk) disable iff (rst || por)
		(evt.poison_rx || evt.poison_tx) && q.supp[UER_B_POISON]
		&& !q.pend[UER_B_POISON] |=> !q.pend[UER_B_POISON];
	endproperty
	a_poison_masked: assert property (p_poison_masked)
		else $error("masked poisoned TLP queued");

	property p_msg_class;
		@(posedge clk) disable iff (rst || por)
		q.msg.valid && $stable(q.cls) |-> q.msg.fatal == q.cls[q.msg.err_pos];
	endproperty
	a_msg_class: assert property (p_msg_class)
		else $error("message class differs from severity");

	property p_cls_reset;
		@(posedge clk) disable iff (rst)
		por |=> q.cls == UER_CLS_RST && q.supp == UER_SUPP_RST;
	endproperty
	a_cls_reset: assert property (p_cls_reset)
		else $error("severity or mask reset value wrong");

	property p_w1c;
		@(posedge clk) disable iff (rst || por)
		bus.wr && bus.addr == UER_FLAGS_OFS && bus.wdata[UER_B_UR]
		&& !evt.unsup_req |=> !q.flags[UER_B_UR];
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("write one did not clear flag");

	property p_warm_keep;
		@(posedge clk) disable iff (por)
		rst |=> q.flags == $past(q.flags) && q.cls == $past(q.cls);
	endproperty
	a_warm_keep: assert property (p_warm_keep)
		else $error("sticky bits lost on warm reset");

	property p_msg_sent;
		@(posedge clk) disable iff (rst || por)
		evt.ecrc && !q.supp[UER_B_ECRC] |=> q.pend[UER_B_ECRC] ##[1:12]
		(q.msg.valid && q.msg.hdr_log && q.msg.err_pos == 5'h13);
	endproperty
	a_msg_sent: assert property (p_msg_sent)
		else $error("unmasked error produced no message");

	property p_irq;
		@(posedge clk) disable iff (rst || por)
		##1 q.irq == |($past(d.flags) & ~$past(d.supp));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt level wrong");

endmodule // uer_regs

// ### tb/test_uer_regs.sv
`timescale 1ns/1ps

module test_uer_regs
	import uer_pkg::*;
;
	logic         clk, rst, por, irq, got, rdv;
	uer_bus_req_t bus;
	uer_evt_t     evt;
	uer_msg_t     msg, last;
	logic [31:0]  rd_data, sev, rs;
	logic [31:0]  rq[$];
	logic [31:0]  mq[$];
	int           n_errors, samples_checked;
	int           pt[12] = '{20, 19, 18, 17, 16, 15, 14, 13, 12, 12, 4, 0};

	uer_regs i_dut (.clk(clk), .rst(rst), .por(por), .bus(bus), .evt(evt),
		.rd_data(rd_data), .msg(msg), .irq(irq));
	uer_rc_model i_rc (.clk(clk), .rst(rst), .msg(msg), .got(got),
		.last(last));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Watcher: oldest note against each read answer and message
	always @(posedge clk) rdv <= bus.rd;
	always @(negedge clk) begin
		if (rdv)
			chk("rd_data", rq.pop_front(), rd_data);
		if (got)
			chk("msg", mq.size() ? mq.pop_front() : 32'hFFFF_FFFF,
				{25'h0, last.hdr_log, last.fatal, last.err_pos});
	end

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		rq.push_back(e);
		@(posedge clk);
		bus.rd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic irq_is(input logic e);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("irq", {31'h0, e}, {31'h0, irq});
		@(posedge clk);
	endtask

	// Pulses events, notes messages in ascending bit order
	task automatic fire(input logic [11:0] v, input logic [31:0] m);
		logic [31:0] ev;
		ev = 32'h0;
		for (int k = 0; k < 12; k++)
			if (v[k])
				ev[pt[k]] = 1'b1;
		for (int b = 0; b < 32; b++)
			if (ev[b] && !m[b])
				mq.push_back({25'h0, 1'b1, sev[b], 5'(b)});
		evt <= uer_evt_t'(v);
		@(posedge clk);
		evt <= '0;
		repeat (20) @(posedge clk);
		chk("msg_left", 32'h0, 32'(mq.size()));
	endtask

	initial begin
		#(25 * 5000);
		n_errors++;
		report_and_stop;
	end

	initial begin
		rst = 1'b1;
		por = 1'b1;
		bus = '0;
		evt = '0;
		sev = UER_CLS_RST;
		rs = 32'h60E0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		rd(UER_FLAGS_OFS, 32'h0);
		rd(UER_SUPP_OFS, 32'h0);
		rd(UER_CLS_OFS, 32'h0006_2011);
		rd(12'h110, 32'h0);
		$display("reset values done");
		for (int k = 0; k < 12; k++) begin
			fire(12'h1 << k, 32'h0);
			irq_is(1'b1);
			rd(UER_FLAGS_OFS, 32'h1 << pt[k]);
			wr(UER_FLAGS_OFS, 32'h1 << pt[k]);
			rd(UER_FLAGS_OFS, 32'h0);
		end
		$display("single events done");
		for (int i = 0; i < 6; i++) begin
			rs = xs(rs);
			sev = rs & UER_IMPL_MASK;
			wr(UER_CLS_OFS, rs);
			rd(UER_CLS_OFS, sev);
			rs = xs(rs);
			fire(rs[11:0], 32'h0);
			wr(UER_FLAGS_OFS, 32'hFFFF_FFFF);
		end
		$display("random severity done");
		wr(UER_SUPP_OFS, 32'hFFFF_FFFF);
		rd(UER_SUPP_OFS, UER_IMPL_MASK);
		fire(12'hFFF, UER_IMPL_MASK);
		irq_is(1'b0);
		wr(UER_FLAGS_OFS, 32'h0);
		rd(UER_FLAGS_OFS, UER_IMPL_MASK);
		wr(UER_SUPP_OFS, 32'h0);
		irq_is(1'b1);
		wr(UER_FLAGS_OFS, 32'hFFFF_FFFF);
		irq_is(1'b0);
		$display("mask done");
		wr(UER_SUPP_OFS, 32'h0000_1000);
		fire(12'h800, 32'h0000_1000);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(UER_SUPP_OFS, 32'h0000_1000);
		rd(UER_FLAGS_OFS, 32'h1);
		rd(UER_CLS_OFS, sev);
		por <= 1'b1;
		repeat (2) @(posedge clk);
		por <= 1'b0;
		rd(UER_SUPP_OFS, 32'h0);
		rd(UER_FLAGS_OFS, 32'h0);
		rd(UER_CLS_OFS, UER_CLS_RST);
		repeat (2) @(posedge clk);
		$display("reset kinds done");
		report_and_stop;
	end
endmodule // test_uer_regs

// ### tb/uer_rc_model.sv
`timescale 1ns/1ps

// Root complex side: accepts every error message the port sends while rst is low
module uer_rc_model
	import uer_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     rst,
	input  wire uer_msg_t msg,
	output      logic     got,
	output      uer_msg_t last
);
	always_ff @(posedge clk) begin
		got  <= !rst && msg.valid;
		last <= msg;
	end
endmodule // uer_rc_model
